// *** logic/ts_defs.svh ***
// register indices, field positions, reset values and timing counts
`ifndef TS_DEFS_SVH
`define TS_DEFS_SVH

// register indices; the byte address is four times the index
`define TS_IDX_PRIMARY_CONTROL 6'h00
`define TS_IDX_MEASURE_TRIGGER_CONTROL 6'h01
`define TS_IDX_MEASURE_MODE_CONTROL 6'h02
`define TS_IDX_IRQ_ENABLE_CLEARER 6'h04
`define TS_IDX_IRQ_ENABLE_SETTER 6'h05
`define TS_IDX_IRQ_FLAG_BITS 6'h06
`define TS_IDX_RESULT_OVERFLOW_STATE 6'h07
`define TS_IDX_SYNC_PENDING_BITS 6'h08
`define TS_IDX_MEASUREMENT_RESULT 6'h0c
`define TS_IDX_WINDOW_LOW_BOUND 6'h10
`define TS_IDX_WINDOW_HIGH_BOUND 6'h14
`define TS_IDX_MEASURE_CYCLE_LENGTH 6'h18
`define TS_IDX_RESULT_CORRECTION 6'h1c
`define TS_IDX_FACTORY_TRIM 6'h20
`define TS_IDX_HALT_BEHAVIOUR_CTRL 6'h24

// field positions
`define TS_BIT_SOFT_RESET 0
`define TS_BIT_ENABLE 1
`define TS_BIT_RUN_STANDBY 6
`define TS_BIT_START 0
`define TS_BIT_FREE_RUN 4
`define TS_BIT_RESULT_OVERFLOW 3
`define TS_BIT_WINDOW_MATCH 2
`define TS_BIT_OVERRUN 1
`define TS_BIT_RESULT_AVAILABLE 0
`define TS_BIT_RUN_WHILE_HALTED 0
`define TS_TEMP_TRIM_LSB 8
`define TS_FREQ_TRIM_LSB 0

// reset values
`define TS_RST_BYTE 8'h00
`define TS_RST_WORD 24'h00_0000
`define TS_RST_TRIM 6'h00

// cycles taken to carry a control change into the sensor clock
`define TS_SYNC_CYCLES 3

`endif

// *** logic/ts_pkg.sv ***
// types shared by the temperature sensor register block
package ts_pkg;

  typedef enum {TS_IDLE, TS_RUN} ts_state_e;

  typedef enum logic [2:0] {
    TS_WIN_OFF = 3'h0,
    TS_WIN_ABOVE = 3'h1,
    TS_WIN_BELOW = 3'h2,
    TS_WIN_INSIDE = 3'h3,
    TS_WIN_OUTSIDE = 3'h4,
    TS_WIN_HYST_ABOVE = 3'h5,
    TS_WIN_HYST_BELOW = 3'h6
  } ts_win_mode_e;

  // one conversion handed over by the analog core
  typedef struct packed {
    logic valid;
    logic overflow;
    logic [23:0] value;
  } ts_raw_s;

endpackage

// *** logic/ts_sync_track.sv ***
// busy tracker for a control change crossing into the sensor clock
`timescale 1ns/100ps
`default_nettype none

module ts_sync_track
#(
  parameter int CYCLES = 3
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  output logic busy,
  output logic done
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count;

  generate
    if (CYCLES < 1)
    begin : g_chk
      $error("ts_sync_track needs CYCLES of at least one");
    end
  endgenerate

  // a new start restarts the count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= '0;
    else if (start)
      count <= CW'(CYCLES);
    else if (count != '0)
      count <= count - CW'(1);
  end

  assign busy = (count != '0);
  assign done = (count == CW'(1)) && !start;

endmodule
`default_nettype wire

// *** logic/ts_window.sv ***
// window monitor compare with hysteresis, match reported one cycle late
`timescale 1ns/100ps
`default_nettype none

module ts_window
  import ts_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic soft_rst,
  input wire logic eval,
  input wire logic [23:0] value,
  input wire logic [2:0] mode,
  input wire logic [23:0] lo,
  input wire logic [23:0] hi,
  output logic match
);

  logic hyst;
  logic now_match;
  logic next_hyst;
  logic above_lo;
  logic below_hi;

  assign above_lo = $signed(value) > $signed(lo);
  assign below_hi = $signed(value) < $signed(hi);

  always_comb
  begin
    next_hyst = hyst;
    now_match = 1'b0;
    case (ts_win_mode_e'(mode))
      TS_WIN_ABOVE: now_match = above_lo;
      TS_WIN_BELOW: now_match = below_hi;
      TS_WIN_INSIDE: now_match = above_lo && below_hi;
      TS_WIN_OUTSIDE: now_match = ($signed(value) < $signed(lo)) || ($signed(value) > $signed(hi));
      TS_WIN_HYST_ABOVE:
      begin
        // armed above high, released only below low
        if ($signed(value) > $signed(hi))
          next_hyst = 1'b1;
        else if ($signed(value) < $signed(lo))
          next_hyst = 1'b0;
        now_match = next_hyst;
      end
      TS_WIN_HYST_BELOW:
      begin
        if ($signed(value) < $signed(lo))
          next_hyst = 1'b1;
        else if ($signed(value) > $signed(hi))
          next_hyst = 1'b0;
        now_match = next_hyst;
      end
      default: next_hyst = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hyst <= 1'b0;
      match <= 1'b0;
    end
    else if (soft_rst)
    begin
      hyst <= 1'b0;
      match <= 1'b0;
    end
    else
    begin
      if (eval)
        hyst <= next_hyst;
      match <= eval && now_match;
    end
  end

endmodule
`default_nettype wire

// *** logic/ts_regs.sv ***
// temperature sensor register block with apb slave and measurement control
`timescale 1ns/100ps
`default_nettype none
`include "ts_defs.svh"

module ts_regs
  import ts_pkg::*;
#(
  parameter int SYNC_CYCLES = `TS_SYNC_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic write_guard,
  input wire logic dbg_halted,
  input wire logic [23:0] nvm_gain,
  input wire logic [23:0] nvm_offset,
  input wire ts_raw_s sensor_in,
  output logic sensor_enable,
  output logic meas_start,
  output logic [23:0] cycle_len,
  output logic [5:0] temperature_trim,
  output logic [5:0] frequency_trim,
  output logic irq
);

  logic [5:0] idx;
  logic wr_acc;
  logic rd_acc;
  logic rd_setup;
  logic blocked;
  logic enable_ctrl;
  logic enable_live;
  logic run_standby;
  logic free_run;
  logic [2:0] window_mode_select;
  logic [3:0] irq_en;
  logic [3:0] irq_flag_bits;
  logic result_overflow;
  logic unread;
  logic [23:0] measurement_result;
  logic [23:0] window_low_bound;
  logic [23:0] window_high_bound;
  logic [23:0] measure_cycle_length;
  logic [23:0] offset_correction;
  logic run_while_halted;
  logic nvm_loaded;
  logic pend_start;
  logic en_sync_start;
  logic en_busy;
  logic en_done;
  logic rst_sync_start;
  logic rst_busy;
  logic soft_rst;
  logic win_match;
  logic got;
  logic got_ovf;
  logic may_run;
  logic [24:0] sum;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  ts_state_e state;
  ts_state_e next_state;

  // known register indices
  function automatic logic is_mapped(input logic [5:0] i);
    case (i)
      `TS_IDX_PRIMARY_CONTROL, `TS_IDX_MEASURE_TRIGGER_CONTROL, `TS_IDX_MEASURE_MODE_CONTROL,
      `TS_IDX_IRQ_ENABLE_CLEARER, `TS_IDX_IRQ_ENABLE_SETTER, `TS_IDX_IRQ_FLAG_BITS,
      `TS_IDX_RESULT_OVERFLOW_STATE, `TS_IDX_SYNC_PENDING_BITS, `TS_IDX_MEASUREMENT_RESULT,
      `TS_IDX_WINDOW_LOW_BOUND, `TS_IDX_WINDOW_HIGH_BOUND, `TS_IDX_MEASURE_CYCLE_LENGTH,
      `TS_IDX_RESULT_CORRECTION, `TS_IDX_FACTORY_TRIM, `TS_IDX_HALT_BEHAVIOUR_CTRL: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // registers closed while enabled
  function automatic logic is_enable_protected(input logic [5:0] i);
    case (i)
      `TS_IDX_MEASURE_MODE_CONTROL, `TS_IDX_WINDOW_LOW_BOUND, `TS_IDX_WINDOW_HIGH_BOUND,
      `TS_IDX_MEASURE_CYCLE_LENGTH, `TS_IDX_RESULT_CORRECTION, `TS_IDX_FACTORY_TRIM: is_enable_protected = 1'b1;
      default: is_enable_protected = 1'b0;
    endcase
  endfunction

  // registers closed by the peripheral write guard
  function automatic logic is_guarded(input logic [5:0] i);
    case (i)
      `TS_IDX_MEASURE_TRIGGER_CONTROL, `TS_IDX_IRQ_FLAG_BITS, `TS_IDX_RESULT_OVERFLOW_STATE,
      `TS_IDX_SYNC_PENDING_BITS, `TS_IDX_MEASUREMENT_RESULT, `TS_IDX_HALT_BEHAVIOUR_CTRL: is_guarded = 1'b0;
      default: is_guarded = 1'b1;
    endcase
  endfunction

  generate
    if (SYNC_CYCLES < 1)
    begin : g_chk
      $error("ts_regs needs SYNC_CYCLES of at least one");
    end
  endgenerate

  assign idx = paddr[7:2];
  assign rd_setup = psel && !penable && !pwrite;
  assign blocked = (is_enable_protected(idx) && enable_ctrl) || (is_guarded(idx) && write_guard);
  assign wr_acc = psel && penable && pwrite && is_mapped(idx) && !blocked;
  assign rd_acc = psel && penable && !pwrite && (idx == `TS_IDX_MEASUREMENT_RESULT);
  assign pready = 1'b1;
  assign pslverr = psel && penable && (!is_mapped(idx) || (pwrite && blocked));

  // control change handoff into the sensor clock
  assign rst_sync_start = wr_acc && (idx == `TS_IDX_PRIMARY_CONTROL) && pwdata[`TS_BIT_SOFT_RESET];
  assign en_sync_start = wr_acc && (idx == `TS_IDX_PRIMARY_CONTROL) && !pwdata[`TS_BIT_SOFT_RESET];

  ts_sync_track #(
    .CYCLES(SYNC_CYCLES)
  ) u_en_sync (
    .pclk(pclk),
    .presetn(presetn),
    .start(en_sync_start && !rst_busy),
    .busy(en_busy),
    .done(en_done)
  );

  ts_sync_track #(
    .CYCLES(SYNC_CYCLES)
  ) u_rst_sync (
    .pclk(pclk),
    .presetn(presetn),
    .start(rst_sync_start && !rst_busy),
    .busy(rst_busy),
    .done(soft_rst)
  );

  // primary and mode control; soft reset wins over the rest of the write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_ctrl <= 1'b0;
      run_standby <= 1'b0;
      free_run <= 1'b0;
      window_mode_select <= 3'h0;
    end
    else if (soft_rst)
    begin
      enable_ctrl <= 1'b0;
      run_standby <= 1'b0;
      free_run <= 1'b0;
      window_mode_select <= 3'h0;
    end
    else if (en_sync_start && !rst_busy)
    begin
      enable_ctrl <= pwdata[`TS_BIT_ENABLE];
      run_standby <= pwdata[`TS_BIT_RUN_STANDBY];
    end
    else if (wr_acc && idx == `TS_IDX_MEASURE_MODE_CONTROL)
    begin
      free_run <= pwdata[`TS_BIT_FREE_RUN];
      window_mode_select <= pwdata[2:0];
    end
  end

  // sensor sees the enable only once the handoff is over
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable_live <= 1'b0;
    else if (soft_rst)
      enable_live <= 1'b0;
    else if (en_done)
      enable_live <= enable_ctrl;
  end

  // shared enable bits behind set and clear views
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_en <= 4'h0;
    else if (soft_rst)
      irq_en <= 4'h0;
    else if (wr_acc && idx == `TS_IDX_IRQ_ENABLE_SETTER)
      irq_en <= irq_en | pwdata[3:0];
    else if (wr_acc && idx == `TS_IDX_IRQ_ENABLE_CLEARER)
      irq_en <= irq_en & ~pwdata[3:0];
  end

  // window bounds
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      window_low_bound <= `TS_RST_WORD;
      window_high_bound <= `TS_RST_WORD;
    end
    else if (soft_rst)
    begin
      window_low_bound <= `TS_RST_WORD;
      window_high_bound <= `TS_RST_WORD;
    end
    else if (wr_acc && idx == `TS_IDX_WINDOW_LOW_BOUND)
      window_low_bound <= pwdata[23:0];
    else if (wr_acc && idx == `TS_IDX_WINDOW_HIGH_BOUND)
      window_high_bound <= pwdata[23:0];
  end

  // calibration set, untouched by soft reset; nvm copy taken after release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nvm_loaded <= 1'b0;
      measure_cycle_length <= `TS_RST_WORD;
      offset_correction <= `TS_RST_WORD;
      temperature_trim <= `TS_RST_TRIM;
      frequency_trim <= `TS_RST_TRIM;
      run_while_halted <= 1'b0;
    end
    else if (!nvm_loaded)
    begin
      nvm_loaded <= 1'b1;
      measure_cycle_length <= nvm_gain;
      offset_correction <= nvm_offset;
    end
    else if (wr_acc)
    begin
      case (idx)
        `TS_IDX_MEASURE_CYCLE_LENGTH: measure_cycle_length <= pwdata[23:0];
        `TS_IDX_RESULT_CORRECTION: offset_correction <= pwdata[23:0];
        `TS_IDX_FACTORY_TRIM:
        begin
          temperature_trim <= pwdata[`TS_TEMP_TRIM_LSB +: 6];
          frequency_trim <= pwdata[`TS_FREQ_TRIM_LSB +: 6];
        end
        `TS_IDX_HALT_BEHAVIOUR_CTRL: run_while_halted <= pwdata[`TS_BIT_RUN_WHILE_HALTED];
        default: nvm_loaded <= 1'b1;
      endcase
    end
  end

  assign cycle_len = measure_cycle_length;
  assign sensor_enable = enable_live;

  // measurement sequencing
  // no new start in the cycle the enable handoff switches the sensor off
  assign may_run = enable_live && !(en_done && !enable_ctrl) && !(dbg_halted && !run_while_halted);

  always_comb
  begin
    next_state = state;
    case (state)
      TS_IDLE:
        if (may_run && (pend_start || free_run))
          next_state = TS_RUN;
      TS_RUN:
        if (sensor_in.valid)
          next_state = TS_IDLE;
      default: next_state = TS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= TS_IDLE;
      meas_start <= 1'b0;
    end
    else if (soft_rst || !enable_live)
    begin
      state <= TS_IDLE;
      meas_start <= 1'b0;
    end
    else
    begin
      state <= next_state;
      meas_start <= (state == TS_IDLE) && (next_state == TS_RUN);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_start <= 1'b0;
    else if (soft_rst)
      pend_start <= 1'b0;
    else if (wr_acc && idx == `TS_IDX_MEASURE_TRIGGER_CONTROL && pwdata[`TS_BIT_START])
      pend_start <= 1'b1;
    else if (state == TS_IDLE && next_state == TS_RUN)
      pend_start <= 1'b0;
  end

  // result landing with offset correction
  assign got = (state == TS_RUN) && sensor_in.valid;
  assign sum = 25'({sensor_in.value[23], sensor_in.value} + {offset_correction[23], offset_correction});
  assign got_ovf = sensor_in.overflow || (sum[24] != sum[23]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      measurement_result <= `TS_RST_WORD;
      result_overflow <= 1'b0;
      unread <= 1'b0;
    end
    else if (soft_rst)
    begin
      measurement_result <= `TS_RST_WORD;
      result_overflow <= 1'b0;
      unread <= 1'b0;
    end
    else if (got && got_ovf)
      result_overflow <= 1'b1;
    else if (got)
    begin
      measurement_result <= sum[23:0];
      result_overflow <= 1'b0;
      unread <= 1'b1;
    end
    else if (rd_acc)
      unread <= 1'b0;
  end

  ts_window u_window (
    .pclk(pclk),
    .presetn(presetn),
    .soft_rst(soft_rst),
    .eval(got && !got_ovf && window_mode_select != 3'h0),
    .value(sum[23:0]),
    .mode(window_mode_select),
    .lo(window_low_bound),
    .hi(window_high_bound),
    .match(win_match)
  );

  // flag events; a set in the clearing cycle wins
  always_comb
  begin
    flag_set = 4'h0;
    flag_set[`TS_BIT_RESULT_OVERFLOW] = got && got_ovf;
    flag_set[`TS_BIT_WINDOW_MATCH] = win_match;
    flag_set[`TS_BIT_OVERRUN] = got && !got_ovf && unread;
    flag_set[`TS_BIT_RESULT_AVAILABLE] = got && !got_ovf;
    flag_clr = 4'h0;
    if (wr_acc && idx == `TS_IDX_IRQ_FLAG_BITS)
      flag_clr = pwdata[3:0];
    if (rd_acc)
    begin
      flag_clr[`TS_BIT_WINDOW_MATCH] = 1'b1;
      flag_clr[`TS_BIT_RESULT_AVAILABLE] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_flag_bits <= 4'h0;
    else if (soft_rst)
      irq_flag_bits <= 4'h0;
    else
      irq_flag_bits <= (irq_flag_bits & ~flag_clr) | flag_set;
  end

  assign irq = |(irq_flag_bits & irq_en);

  // read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
    begin
      case (idx)
        `TS_IDX_PRIMARY_CONTROL:
          prdata <= {25'h0, run_standby, 4'h0, enable_ctrl, rst_busy};
        `TS_IDX_MEASURE_MODE_CONTROL:
          prdata <= {27'h0, free_run, 1'b0, window_mode_select};
        `TS_IDX_IRQ_ENABLE_CLEARER, `TS_IDX_IRQ_ENABLE_SETTER:
          prdata <= {28'h0, irq_en};
        `TS_IDX_IRQ_FLAG_BITS:
          prdata <= {28'h0, irq_flag_bits};
        `TS_IDX_RESULT_OVERFLOW_STATE:
          prdata <= {31'h0, result_overflow};
        `TS_IDX_SYNC_PENDING_BITS:
          prdata <= {30'h0, en_busy, rst_busy};
        `TS_IDX_MEASUREMENT_RESULT:
          prdata <= {8'h00, measurement_result};
        `TS_IDX_WINDOW_LOW_BOUND:
          prdata <= {8'h00, window_low_bound};
        `TS_IDX_WINDOW_HIGH_BOUND:
          prdata <= {8'h00, window_high_bound};
        `TS_IDX_MEASURE_CYCLE_LENGTH:
          prdata <= {8'h00, measure_cycle_length};
        `TS_IDX_RESULT_CORRECTION:
          prdata <= {8'h00, offset_correction};
        `TS_IDX_FACTORY_TRIM:
          prdata <= {18'h0, temperature_trim, 2'h0, frequency_trim};
        `TS_IDX_HALT_BEHAVIOUR_CTRL:
          prdata <= {31'h0, run_while_halted};
        default:
          prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** testbench/ts_sensor_model.sv ***
// behavioural analog core answering start pulses
`timescale 1ns/100ps
`default_nettype none
module ts_sensor_model
  import ts_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic meas_start,
  input wire logic slow,
  input wire logic ovf,
  input wire logic [23:0] value,
  output var ts_raw_s sensor_out
);
  int cnt;
  logic [23:0] last;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 0;
      last <= 24'h00_0000;
      sensor_out <= '0;
    end
    else
    begin
      // stale data is never left on the value lines
      sensor_out <= {1'b0, 1'b0, ~last};
      if (meas_start)
        cnt <= slow ? 9 : 1;
      else if (cnt == 1)
      begin
        sensor_out <= {1'b1, ovf, value};
        last <= value;
        cnt <= 0;
      end
      else if (cnt > 1)
        cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// *** testbench/ts_regs_assertions.sv ***
// port checker for the temperature sensor register block
`timescale 1ns/100ps
`default_nettype none
module ts_regs_assertions
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic write_guard,
  input wire logic sensor_enable,
  input wire logic meas_start,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic rd_acc = psel && penable && !pwrite;
  wire logic wr_acc = psel && penable && pwrite;
  property p_res_top;
    rd_acc && paddr[7:2] == 6'h0c |-> prdata[31:24] == 8'h00;
  endproperty
  a_res_top: assert property (p_res_top) else $error("result upper byte not zero");
  property p_stat_bits;
    rd_acc && paddr[7:2] == 6'h07 |-> prdata[31:1] == 31'h0000_0000;
  endproperty
  a_stat_bits: assert property (p_stat_bits) else $error("status spare bits set");
  property p_sync_bits;
    rd_acc && paddr[7:2] == 6'h08 |-> prdata[31:2] == 30'h0000_0000;
  endproperty
  a_sync_bits: assert property (p_sync_bits) else $error("sync spare bits set");
  property p_flag_bits;
    rd_acc && paddr[7:2] == 6'h06 |-> prdata[31:4] == 28'h000_0000;
  endproperty
  a_flag_bits: assert property (p_flag_bits) else $error("flag spare bits set");
  property p_guard;
    wr_acc && write_guard && paddr[7:2] == 6'h10 |-> pslverr;
  endproperty
  a_guard: assert property (p_guard) else $error("guarded write not refused");
  property p_start_en;
    $rose(meas_start) |-> sensor_enable ##1 !meas_start;
  endproperty
  a_start_en: assert property (p_start_en) else $error("start while off or too long");
  property p_start_idle;
    !sensor_enable |-> !meas_start;
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("start while disabled");
  property p_en_clear;
    wr_acc && !write_guard && paddr[7:2] == 6'h04 && pwdata[3:0] == 4'hf |=> !irq [*2];
  endproperty
  a_en_clear: assert property (p_en_clear) else $error("irq after enables cleared");
  c_guard: cover property (wr_acc && pslverr);
  c_start: cover property (meas_start);
  c_irq: cover property ($rose(irq));
endmodule
bind ts_regs ts_regs_assertions chk_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pslverr, .write_guard, .sensor_enable, .meas_start, .irq
);
`default_nettype wire

// *** testbench/ts_regs_tb.sv ***
// self-checking bench for the temperature sensor register block
`timescale 1ns/100ps
`default_nettype none
module ts_regs_tb;
  import ts_pkg::*;
  typedef struct packed {logic w; logic [5:0] i; logic [31:0] d; logic [31:0] e; logic er;} ts_row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic write_guard = 1'b0, dbg_halted = 1'b0, slow = 1'b0, ovf = 1'b0;
  logic sensor_enable, meas_start, irq;
  logic [23:0] cycle_len, sval = 24'hff_fffe;
  logic [5:0] temperature_trim, frequency_trim;
  ts_raw_s sensor_in;
  int fails = 0, tests_run = 0, n;
  ts_row_s rows[26] = '{
    '{1'b0, 6'h05, '0, '0, 1'b0}, '{1'b0, 6'h06, '0, '0, 1'b0}, '{1'b0, 6'h07, '0, '0, 1'b0},
    '{1'b0, 6'h08, '0, '0, 1'b0}, '{1'b0, 6'h0c, '0, '0, 1'b0},
    '{1'b0, 6'h18, '0, 32'h0000_0123, 1'b0}, '{1'b0, 6'h1c, '0, 32'h0000_0005, 1'b0},
    '{1'b1, 6'h05, 32'h0000_0005, '0, 1'b0}, '{1'b1, 6'h05, '0, '0, 1'b0},
    '{1'b0, 6'h04, '0, 32'h0000_0005, 1'b0}, '{1'b1, 6'h04, 32'h0000_0001, '0, 1'b0},
    '{1'b0, 6'h05, '0, 32'h0000_0004, 1'b0}, '{1'b1, 6'h10, 32'hffff_ffff, '0, 1'b0},
    '{1'b0, 6'h10, '0, 32'h00ff_ffff, 1'b0}, '{1'b1, 6'h14, 32'h0000_0010, '0, 1'b0},
    '{1'b0, 6'h14, '0, 32'h0000_0010, 1'b0}, '{1'b1, 6'h07, 32'h0000_0001, '0, 1'b0},
    '{1'b0, 6'h07, '0, '0, 1'b0}, '{1'b1, 6'h20, 32'h0000_3f3f, '0, 1'b0},
    '{1'b0, 6'h20, '0, 32'h0000_3f3f, 1'b0}, '{1'b1, 6'h24, 32'h0000_0001, '0, 1'b0},
    '{1'b0, 6'h24, '0, 32'h0000_0001, 1'b0}, '{1'b0, 6'h03, '0, '0, 1'b1},
    '{1'b1, 6'h02, 32'h0000_0003, '0, 1'b0}, '{1'b1, 6'h18, 32'h0000_0020, '0, 1'b0},
    '{1'b0, 6'h18, '0, 32'h0000_0020, 1'b0}};
  ts_regs #(.SYNC_CYCLES(6)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .write_guard, .dbg_halted, .nvm_gain(24'h00_0123), .nvm_offset(24'h00_0005), .sensor_in,
    .sensor_enable, .meas_start, .cycle_len, .temperature_trim, .frequency_trim, .irq);
  ts_sensor_model model_u (.pclk, .presetn, .meas_start, .slow, .ovf, .value(sval), .sensor_out(sensor_in));
  initial
  begin
    forever #20 pclk = ~pclk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      fails++;
      stop_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0000_0000);
    chk(rdat, e);
  endtask
  task automatic wait_for(input int lim);
    n = 0;
    while (sensor_in.valid !== 1'b1 && sensor_enable !== 1'b0 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim)
    begin
      fails++;
      stop_test();
    end
    repeat (3) @(posedge pclk);
  endtask
  task automatic wait_en;
    n = 0;
    while (sensor_enable !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (sensor_enable !== 1'b1)
    begin
      fails++;
      stop_test();
    end
  endtask
  task automatic meas;
    apb(1'b1, 6'h01, 32'h0000_0001);
    wait_for(40);
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[k])
    begin
      apb(rows[k].w, rows[k].i, rows[k].d);
      if (!rows[k].w)
        chk(rdat, rows[k].e);
      chk({31'h0000_0000, rerr}, {31'h0000_0000, rows[k].er});
    end
    chk({8'h00, cycle_len}, 32'h0000_0020);
    chk({20'h0_0000, temperature_trim, frequency_trim}, 32'h0000_0fff);
    $display("test rows done");
    apb(1'b1, 6'h00, 32'h0000_0002);
    rd(6'h08, 32'h0000_0002);
    wait_en();
    rd(6'h08, 32'h0000_0000);
    apb(1'b1, 6'h14, 32'h0000_0020);
    chk({31'h0000_0000, rerr}, 32'h0000_0001);
    rd(6'h14, 32'h0000_0010);
    meas();
    rd(6'h06, 32'h0000_0005);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    rd(6'h0c, 32'h0000_0003);
    rd(6'h06, 32'h0000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    $display("test result done");
    slow <= 1'b1;
    meas();
    meas();
    rd(6'h06, 32'h0000_0007);
    apb(1'b1, 6'h06, 32'h0000_0002);
    rd(6'h06, 32'h0000_0005);
    apb(1'b1, 6'h06, 32'h0000_000f);
    rd(6'h06, 32'h0000_0000);
    $display("test overrun done");
    ovf <= 1'b1;
    apb(1'b1, 6'h05, 32'h0000_0008);
    meas();
    apb(1'b0, 6'h06, 32'h0000_0000);
    chk(rdat & 32'h0000_0009, 32'h0000_0008);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    rd(6'h07, 32'h0000_0001);
    apb(1'b1, 6'h04, 32'h0000_000f);
    @(posedge pclk);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    ovf <= 1'b0;
    $display("test overflow done");
    apb(1'b1, 6'h24, 32'h0000_0000);
    dbg_halted <= 1'b1;
    apb(1'b1, 6'h01, 32'h0000_0001);
    n = 0;
    repeat (10)
    begin
      @(posedge pclk);
      if (meas_start === 1'b1)
        n++;
    end
    chk(n, 32'h0000_0000);
    dbg_halted <= 1'b0;
    $display("test halt done");
    apb(1'b1, 6'h00, 32'h0000_0001);
    rd(6'h08, 32'h0000_0001);
    repeat (10) @(posedge pclk);
    rd(6'h08, 32'h0000_0000);
    rd(6'h05, 32'h0000_0000);
    rd(6'h02, 32'h0000_0000);
    rd(6'h18, 32'h0000_0020);
    rd(6'h20, 32'h0000_3f3f);
    chk({31'h0000_0000, sensor_enable}, 32'h0000_0000);
    write_guard <= 1'b1;
    apb(1'b1, 6'h10, 32'h0000_0001);
    chk({31'h0000_0000, rerr}, 32'h0000_0001);
    write_guard <= 1'b0;
    rd(6'h10, 32'h0000_0000);
    $display("test reset done");
    apb(1'b1, 6'h02, 32'h0000_0001);
    apb(1'b1, 6'h00, 32'h0000_0002);
    wait_en();
    meas();
    rd(6'h06, 32'h0000_0005);
    rd(6'h0c, 32'h0000_0003);
    $display("test window mode done");
    stop_test();
  end
endmodule
`default_nettype wire
